// *** rtl/vmon_status_flags.sv ***
/*
  Supply-monitor status flag bank: three read-only 8-bit status registers
  fed by internal and outside voltage monitors, read by the host through
  dedicated read commands.
  Assumes the serial framing decodes a read into a one-cycle strobe with a
  register select; read data is returned in the cycle after the strobe.
*/
// What this block does
// - flags set on a fault and hold until their register is read
// - a read clears only set flags whose condition has gone
// - power-on reset zeroes all flags; reads are the other clearing source
// - undervoltage register bits 6,4,3,1,0; bits 7,5,2 read zero
// - overvoltage register bits 7,6,4,3,1,0; bits 5,2 read zero
// - input overvoltage flag equals the off-state latched copy
// - external register bits 5,4,1,0; bits 7-6 and 3-2 read zero
// - a disabled outside monitor cannot set its flags
// - registers are read only; no write path exists
// - enable bits 5 and 4 of power control, kept across device reset
`timescale 1ns/1ps
module vmon_status_flags
  import vmon_status_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  fault_vec_t       fault_in,
  input  wire logic [7:0]  power_control_in,
  input  wire logic        read_strobe_in,
  input  status_sel_t      read_sel_in,
  output logic      [7:0]  read_data_out,
  output logic             read_valid_out,
  output logic             input_supply_overvoltage_flag_out
);

  fault_vec_t fault_sync;
  logic [7:0] ext_cond;
  logic [7:0] uv_flags;
  logic [7:0] ov_flags;
  logic [7:0] ext_flags;
  logic       clear_uv;
  logic       clear_ov;
  logic       clear_ext;
  logic       outside_monitor_one_enable;
  logic       outside_monitor_two_enable;
  logic [7:0] read_data_reg;
  logic [7:0] read_data_next;
  logic       read_valid_reg;
  logic       read_valid_next;

  // comparator outputs cross into the register clock
  fault_sync #(
    .WIDTH ($bits(fault_vec_t))
  ) u_sync (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (fault_in),
    .sync_out   (fault_sync)
  );

  // enable bits live in a control register kept outside, not reset here
  assign outside_monitor_one_enable = power_control_in[EN_ONE_BIT];
  assign outside_monitor_two_enable = power_control_in[EN_TWO_BIT];

  // disabled monitors are masked before they can set a flag
  always_comb begin
    ext_cond = '0;
    ext_cond[EXT_ONE_OV_BIT] = fault_sync.external[EXT_ONE_OV_BIT]
                               & outside_monitor_one_enable;
    ext_cond[EXT_ONE_UV_BIT] = fault_sync.external[EXT_ONE_UV_BIT]
                               & outside_monitor_one_enable;
    ext_cond[EXT_TWO_OV_BIT] = fault_sync.external[EXT_TWO_OV_BIT]
                               & outside_monitor_two_enable;
    ext_cond[EXT_TWO_UV_BIT] = fault_sync.external[EXT_TWO_UV_BIT]
                               & outside_monitor_two_enable;
  end

  // a read strobe clears only the selected register; no write
  assign clear_uv  = read_strobe_in && read_sel_in == SEL_UNDERVOLTAGE;
  assign clear_ov  = read_strobe_in && read_sel_in == SEL_OVERVOLTAGE;
  assign clear_ext = read_strobe_in && read_sel_in == SEL_EXTERNAL;

  sticky_flags #(
    .IMPL_MASK (UV_IMPL_MASK)
  ) u_uv (
    .sys_clk_in    (sys_clk_in),
    .reset_n_in    (reset_n_in),
    .cond_in       (fault_sync.undervoltage),
    .read_clear_in (clear_uv),
    .flags_out     (uv_flags)
  );

  sticky_flags #(
    .IMPL_MASK (OV_IMPL_MASK)
  ) u_ov (
    .sys_clk_in    (sys_clk_in),
    .reset_n_in    (reset_n_in),
    .cond_in       (fault_sync.overvoltage),
    .read_clear_in (clear_ov),
    .flags_out     (ov_flags)
  );

  sticky_flags #(
    .IMPL_MASK (EXT_IMPL_MASK)
  ) u_ext (
    .sys_clk_in    (sys_clk_in),
    .reset_n_in    (reset_n_in),
    .cond_in       (ext_cond),
    .read_clear_in (clear_ext),
    .flags_out     (ext_flags)
  );

  // read data is the pre-clear value, so a set flag is always reported once
  always_comb begin
    read_data_next  = read_data_reg;
    read_valid_next = read_strobe_in;
    if (read_strobe_in) begin
      unique case (read_sel_in)
        SEL_UNDERVOLTAGE: read_data_next = uv_flags & UV_IMPL_MASK;
        SEL_OVERVOLTAGE:  read_data_next = ov_flags & OV_IMPL_MASK;
        SEL_EXTERNAL:     read_data_next = ext_flags & EXT_IMPL_MASK;
        SEL_NONE:         read_data_next = STATUS_RESET;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      read_data_reg  <= STATUS_RESET;
      read_valid_reg <= 1'b0;
    end else begin
      read_data_reg  <= read_data_next;
      read_valid_reg <= read_valid_next;
    end
  end

  assign read_data_out  = read_data_reg;
  assign read_valid_out = read_valid_reg;
  // the off-state latched register mirrors this flag bit directly
  assign input_supply_overvoltage_flag_out = ov_flags[OV_INPUT_BIT];

  // flags hold while the condition persists through a read
  chk_persist_after_read: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clear_uv && uv_flags[UV_PRE_BIT] && fault_sync.undervoltage[UV_PRE_BIT]
    |=> uv_flags[UV_PRE_BIT])
    else $error("flag lost while condition persists");

  chk_clear_on_read: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clear_ov && !fault_sync.overvoltage[OV_IO_BIT]
    |=> !ov_flags[OV_IO_BIT])
    else $error("flag not cleared by read");

  chk_sticky_hold: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    ov_flags[OV_PRE_BIT] && !clear_ov |=> ov_flags[OV_PRE_BIT])
    else $error("flag dropped without a read");

  chk_set_on_fault: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    fault_sync.undervoltage[UV_INPUT_BIT] |=> uv_flags[UV_INPUT_BIT])
    else $error("fault did not set flag");

  chk_sync_latency: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    $rose(fault_in.undervoltage[UV_STEP_UP_BIT]) ##1
    fault_in.undervoltage[UV_STEP_UP_BIT] ##1
    fault_in.undervoltage[UV_STEP_UP_BIT]
    |=> uv_flags[UV_STEP_UP_BIT])
    else $error("synchronised fault not latched in time");

  chk_reserved_zero: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    read_valid_out |->
    (read_data_out & ~(($past(read_sel_in) == SEL_UNDERVOLTAGE) ? UV_IMPL_MASK
      : ($past(read_sel_in) == SEL_OVERVOLTAGE) ? OV_IMPL_MASK
      : EXT_IMPL_MASK)) == 8'h00
    && (uv_flags & ~UV_IMPL_MASK) == 8'h00
    && (ov_flags & ~OV_IMPL_MASK) == 8'h00
    && (ext_flags & ~EXT_IMPL_MASK) == 8'h00)
    else $error("reserved bit set");

  chk_mask_disabled: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    !outside_monitor_one_enable && !ext_flags[EXT_ONE_OV_BIT]
    |=> !ext_flags[EXT_ONE_OV_BIT])
    else $error("disabled monitor set a flag");

  chk_read_data: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    read_strobe_in && read_sel_in == SEL_OVERVOLTAGE
    |=> read_valid_out && read_data_out == $past(ov_flags))
    else $error("read data does not match register");

  chk_mirror_flag: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    input_supply_overvoltage_flag_out == ov_flags[OV_INPUT_BIT])
    else $error("mirror flag differs");

  chk_reset_zero: assert property (
    @(posedge sys_clk_in)
    $rose(reset_n_in) |-> uv_flags == 8'h00 && ov_flags == 8'h00
    && ext_flags == 8'h00)
    else $error("flags not zero after reset");

endmodule

// *** rtl/vmon_status_pkg.sv ***
/*
  Shared constants and types for the supply-monitor status flag bank.
  Assumes a single register clock and an active-low asynchronous reset.
*/
package vmon_status_pkg;

  localparam int STATUS_WIDTH = 8;

  // register selection codes carried by the read command
  typedef enum logic [1:0] {
    SEL_UNDERVOLTAGE = 2'h0,
    SEL_OVERVOLTAGE  = 2'h1,
    SEL_EXTERNAL     = 2'h2,
    SEL_NONE         = 2'h3
  } status_sel_t;

  // undervoltage_status field positions
  localparam int UV_INPUT_BIT    = 6;
  localparam int UV_REGULATR_BIT = 4;
  localparam int UV_STEP_UP_BIT  = 3;
  localparam int UV_SECOND_BIT   = 1;
  localparam int UV_PRE_BIT      = 0;
  // overvoltage_status field positions
  localparam int OV_IO_BIT       = 7;
  localparam int OV_INPUT_BIT    = 6;
  localparam int OV_REGULATR_BIT = 4;
  localparam int OV_STEP_UP_BIT  = 3;
  localparam int OV_SECOND_BIT   = 1;
  localparam int OV_PRE_BIT      = 0;
  // external_monitor_status field positions
  localparam int EXT_TWO_OV_BIT  = 5;
  localparam int EXT_TWO_UV_BIT  = 4;
  localparam int EXT_ONE_OV_BIT  = 1;
  localparam int EXT_ONE_UV_BIT  = 0;
  // enable bit positions in the power control register
  localparam int EN_TWO_BIT      = 5;
  localparam int EN_ONE_BIT      = 4;

  // implemented-bit masks, unimplemented bits read zero
  localparam logic [7:0] UV_IMPL_MASK  = 8'h5B;
  localparam logic [7:0] OV_IMPL_MASK  = 8'hDB;
  localparam logic [7:0] EXT_IMPL_MASK = 8'h33;
  localparam logic [7:0] STATUS_RESET  = 8'h00;

  localparam int SYNC_STAGES = 2;

  // raw comparator conditions, one word per status register
  typedef struct packed {
    logic [7:0] undervoltage;
    logic [7:0] overvoltage;
    logic [7:0] external;
  } fault_vec_t;

endpackage

// *** rtl/fault_sync.sv ***
/*
  Two-stage level synchroniser for a vector of comparator outputs.
  Assumes inputs may change at any time relative to sys_clk_in.
*/
`timescale 1ns/1ps
module fault_sync
  import vmon_status_pkg::*;
#(
  parameter int WIDTH = 24
) (
  input  wire logic             sys_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule

// *** rtl/sticky_flags.sv ***
/*
  One 8-bit status register of sticky, read-to-clear flags.
  Assumes conditions are already synchronous and masked.
*/
`timescale 1ns/1ps
module sticky_flags
  import vmon_status_pkg::*;
#(
  parameter logic [7:0] IMPL_MASK = 8'hFF
) (
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic [7:0] cond_in,
  input  wire logic       read_clear_in,
  output logic      [7:0] flags_out
);

  logic [7:0] flags_reg;
  logic [7:0] flags_next;

  // set wins; a read drops only flags whose condition is gone
  always_comb begin
    flags_next = flags_reg | (cond_in & IMPL_MASK);
    if (read_clear_in) begin
      flags_next = (flags_reg & cond_in & IMPL_MASK) | (cond_in & IMPL_MASK);
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_reg <= STATUS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags_out = flags_reg;

endmodule

// *** tb/vmon_host_model.sv ***
/*
  Host-side model: issues the dedicated read commands to the status bank.
  Assumes the bench calls read_cmd; drives at the falling clock edge.
*/
`timescale 1ns/1ps
module vmon_host_model
  import vmon_status_pkg::*;
(
  input  wire logic  sys_clk_in,
  output logic       read_strobe_out,
  output status_sel_t read_sel_out
);
  initial begin
    read_strobe_out = 1'b0;
    read_sel_out    = SEL_NONE;
  end

  // one-cycle read command, the only access offered
  task automatic read_cmd(input status_sel_t sel);
    @(negedge sys_clk_in);
    read_strobe_out = 1'b1;
    read_sel_out    = sel;
    @(negedge sys_clk_in);
    read_strobe_out = 1'b0;
    // select is meaningless once the strobe drops
    read_sel_out    = status_sel_t'(~sel);
  endtask
endmodule

// *** tb/tb_vmon_status_flags.sv ***
/*
  Self-checking bench for the supply-monitor status flag bank.
  Assumes vmon_host_model issues reads; faults driven at falling edges.
*/
`timescale 1ns/1ps
module tb_vmon_status_flags;
  import vmon_status_pkg::*;
  logic        sys_clk_in;
  logic        reset_n_in;
  fault_vec_t  fault;
  logic [7:0]  power_control;
  logic        read_strobe;
  status_sel_t read_sel;
  logic [7:0]  read_data;
  logic        read_valid;
  logic        mirror;
  logic [7:0]  exp_q[$];
  logic [7:0]  eu, eo, ee, em;
  int          miscompares, comparisons, cycles, seed, i;

  vmon_status_flags dut_u (
    .sys_clk_in                        (sys_clk_in),
    .reset_n_in                        (reset_n_in),
    .fault_in                          (fault),
    .power_control_in                  (power_control),
    .read_strobe_in                    (read_strobe),
    .read_sel_in                       (read_sel),
    .read_data_out                     (read_data),
    .read_valid_out                    (read_valid),
    .input_supply_overvoltage_flag_out (mirror)
  );

  vmon_host_model host_u (
    .sys_clk_in      (sys_clk_in),
    .read_strobe_out (read_strobe),
    .read_sel_out    (read_sel)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  task automatic check(input logic [7:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rd(input status_sel_t sel, input logic [7:0] exp);
    exp_q.push_back(exp);
    host_u.read_cmd(sel);
  endtask

  task automatic rd_all(input logic [7:0] a, b, c);
    rd(SEL_UNDERVOLTAGE, a);
    rd(SEL_OVERVOLTAGE, b);
    rd(SEL_EXTERNAL, c);
  endtask

  task automatic drive(input logic [7:0] u, o, e);
    @(negedge sys_clk_in);
    fault = {u, o, e};
    repeat (5) @(negedge sys_clk_in);
  endtask

  task automatic end_of_test();
    if (exp_q.size() != 0) begin
      miscompares++;
      $display("[FAIL] %0t reads never answered", $time);
    end
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // each answer is matched with the oldest expectation
  always @(negedge sys_clk_in) begin
    if (read_valid === 1'b1) begin
      em = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
      check(read_data, em, "read data");
    end
  end

  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_of_test();
    end
  end

  initial begin
    seed = 11504;
    reset_n_in = 1'b0;
    fault = '0;
    power_control = 8'h00;
    repeat (5) @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    rd_all(8'h00, 8'h00, 8'h00);
    rd(SEL_NONE, 8'h00);
    $display("test reset values done");
    for (i = 0; i < 6; i++) begin
      power_control = 8'($random(seed));
      eu = 8'($random(seed));
      eo = 8'($random(seed));
      ee = 8'($random(seed));
      drive(eu, eo, ee);
      eu &= 8'h5B;
      eo &= 8'hDB;
      ee &= 8'h33 & {2'h0, {2{power_control[5]}},
                     2'h0, {2{power_control[4]}}};
      check({7'h00, mirror}, {7'h00, eo[6]}, "mirror set");
      rd(SEL_NONE, 8'h00);
      rd_all(eu, eo, ee);
      rd_all(eu, eo, ee);
      drive(8'h00, 8'h00, 8'h00);
      check({7'h00, mirror}, {7'h00, eo[6]}, "mirror held");
      rd_all(eu, eo, ee);
      rd_all(8'h00, 8'h00, 8'h00);
      check({7'h00, mirror}, 8'h00, "mirror clear");
      $display("test sticky flags pass %0d done", i);
    end
    // a new fault reaches its flag at the very edge that takes a read
    @(negedge sys_clk_in);
    fault.undervoltage = 8'h5B;
    @(negedge sys_clk_in);
    rd(SEL_UNDERVOLTAGE, 8'h00);
    rd(SEL_UNDERVOLTAGE, 8'h5B);
    drive(8'h00, 8'h00, 8'h00);
    rd(SEL_UNDERVOLTAGE, 8'h5B);
    rd(SEL_UNDERVOLTAGE, 8'h00);
    $display("test set beats clear done");
    power_control = 8'h30;
    drive(8'hFF, 8'hFF, 8'hFF);
    drive(8'h00, 8'h00, 8'h00);
    reset_n_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    rd_all(8'h00, 8'h00, 8'h00);
    repeat (2) @(negedge sys_clk_in);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule
